// >>> src/cpfm_pkg.sv
// Package: offsets, field layouts, reset values and types of the pin mux
package cpfm_pkg;

  // Register offsets on the control interface
  localparam logic [7:0] ADDR_INPUT_PIN_CONFIG = 8'h0D;
  localparam logic [7:0] ADDR_PIN_VALUES       = 8'h0E;
  localparam logic [7:0] ADDR_ROUTING_CFG0     = 8'h0F;
  localparam logic [7:0] ADDR_SERIAL_OUT_CFG   = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_INPUT_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_VALUES       = 8'h00;
  localparam logic [7:0] RST_ROUTING_CFG0     = 8'h00;
  localparam logic [7:0] RST_SERIAL_OUT_CFG   = 8'h52;

  // Writable bits of each register; the rest read back as reset value, except pin value monitor bits 3-1
  localparam logic [7:0] WMASK_INPUT_PIN_CONFIG = 8'h03;
  localparam logic [7:0] WMASK_PIN_VALUES       = 8'hE0;
  localparam logic [7:0] WMASK_ROUTING_CFG0     = 8'h7F;
  localparam logic [7:0] WMASK_SERIAL_OUT_CFG   = 8'hFF;

  // Field positions
  localparam int unsigned POS_INPUT_PIN_ENABLE = 1;
  localparam int unsigned POS_BIDIR_A_OUT      = 7;
  localparam int unsigned POS_BIDIR_B_OUT      = 6;
  localparam int unsigned POS_OUTONLY_OUT      = 5;
  localparam int unsigned POS_BIDIR_A_IN       = 3;
  localparam int unsigned POS_BIDIR_B_IN       = 2;
  localparam int unsigned POS_INONLY_IN        = 1;
  localparam int unsigned POS_AUX_CLK_SEL      = 5;
  localparam int unsigned POS_DIN2_SEL         = 2;
  localparam int unsigned POS_BITCLK_SRC       = 1;
  localparam int unsigned POS_FSYNC_SRC        = 0;
  localparam int unsigned POS_SOUT_FUNC        = 4;
  localparam int unsigned POS_SOUT_LEVEL       = 3;
  localparam int unsigned POS_SOUT_DRIVE       = 0;

  // Input synchroniser depth and bit indices
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned SI_BIDIR_A   = 0;
  localparam int unsigned SI_BIDIR_B   = 1;
  localparam int unsigned SI_INONLY    = 2;
  localparam int unsigned SI_SOUT      = 3;
  localparam int unsigned SI_PRI_DIN   = 4;
  localparam int unsigned SI_BITCLK    = 5;
  localparam int unsigned SI_FSYNC     = 6;
  localparam int unsigned SI_SEC_BCLK  = 7;
  localparam int unsigned SI_SEC_FSYNC = 8;
  localparam int unsigned SYNC_W       = 9;

  // Driven pin indices
  localparam int unsigned PIN_A       = 0;
  localparam int unsigned PIN_B       = 1;
  localparam int unsigned PIN_OUTONLY = 2;
  localparam int unsigned PIN_SOUT    = 3;
  localparam int unsigned NUM_PINS    = 4;

  // Pin function codes
  typedef enum logic [3:0] {
    FN_DISABLED  = 4'h0, FN_INPUT     = 4'h1, FN_GPO       = 4'h2,
    FN_IRQ       = 4'h3, FN_DMIC_CLK  = 4'h4, FN_PRI_DOUT  = 4'h5,
    FN_PRI_DOUT2 = 4'h6, FN_SEC_DOUT  = 4'h7, FN_SEC_DOUT2 = 4'h8,
    FN_SEC_BCLK  = 4'h9, FN_SEC_FSYNC = 4'hA, FN_GEN_CLK   = 4'hB,
    FN_MUX_DOUT  = 4'hC, FN_DAISY     = 4'hD, FN_LOOPBACK  = 4'hE,
    FN_RSVD      = 4'hF
  } cpfm_func_e;

  // Drive styles
  typedef enum logic [2:0] {
    DRV_HIZ        = 3'h0, DRV_PUSH_PULL   = 3'h1, DRV_LOW_WEAKHI = 3'h2,
    DRV_LOW_ONLY   = 3'h3, DRV_WEAKLO_HIGH = 3'h4, DRV_HIGH_ONLY  = 3'h5,
    DRV_RSVD6      = 3'h6, DRV_RSVD7       = 3'h7
  } cpfm_drive_e;

  // Internal sources a pin can carry
  typedef struct packed {
    logic irq;
    logic dmic_clk;
    logic pri_dout;
    logic pri_dout2;
    logic sec_dout;
    logic sec_dout2;
    logic sec_bclk;
    logic sec_fsync;
    logic gen_clk;
    logic mux_dout;
    logic daisy_out;
  } cpfm_src_s;

  // Per-pin configuration
  typedef struct packed {
    cpfm_func_e  func;
    logic        level;
    cpfm_drive_e drive;
  } cpfm_pin_cfg_s;

  // Pad controls: data, strong enable, weak pull up, weak pull down
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
  } cpfm_pad_s;

endpackage

// >>> src/cpfm_pin_drv.sv
// One output pin: function select and drive style, registered pad controls
`timescale 1ns/10ps
module cpfm_pin_drv (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_srst,
  input  wire cpfm_pkg::cpfm_pin_cfg_s i_cfg,
  input  wire cpfm_pkg::cpfm_src_s    i_src,
  input  wire logic                   i_loop_data,
  input  wire logic                   i_has_loop,
  input  wire logic                   i_drive_on_serial,
  output cpfm_pkg::cpfm_pad_s         o_pad
);
  import cpfm_pkg::*;

  logic      data;
  logic      active;
  logic      serial;
  cpfm_pad_s next_pad;

  ////////////////////////////////////////
  // Function select
  always_comb begin
    data   = 1'b0;
    active = 1'b1;
    serial = i_cfg.func inside {FN_PRI_DOUT, FN_PRI_DOUT2, FN_SEC_DOUT, FN_SEC_DOUT2,
                                FN_SEC_BCLK, FN_SEC_FSYNC, FN_MUX_DOUT, FN_DAISY,
                                FN_LOOPBACK};                  // [RQ18]
    unique case (i_cfg.func)
      FN_DISABLED, FN_INPUT: active = 1'b0;
      FN_GPO:       data = i_cfg.level;                        // [RQ3] [RQ4] [RQ5] [RQ15]
      FN_IRQ:       data = i_src.irq;
      FN_DMIC_CLK:  data = i_src.dmic_clk;
      FN_PRI_DOUT:  data = i_src.pri_dout;                     // [RQ13]
      FN_PRI_DOUT2: data = i_src.pri_dout2;
      FN_SEC_DOUT:  data = i_src.sec_dout;
      FN_SEC_DOUT2: data = i_src.sec_dout2;
      FN_SEC_BCLK:  data = i_src.sec_bclk;
      FN_SEC_FSYNC: data = i_src.sec_fsync;
      FN_GEN_CLK:   data = i_src.gen_clk;
      FN_MUX_DOUT:  data = i_src.mux_dout;
      FN_DAISY:     data = i_src.daisy_out;
      // Loopback exists only where the caller says so
      FN_LOOPBACK:  begin                                      // [RQ14]
        data   = i_loop_data;
        active = i_has_loop;
      end
      FN_RSVD:      active = 1'b0;                             // [RQ14]
    endcase
  end

  ////////////////////////////////////////
  // Drive style; reserved codes float the pin rather than guess a style
  always_comb begin
    next_pad = '0;
    next_pad.out = data;
    if (active && serial && !i_drive_on_serial) begin
      next_pad.oe = 1'b1;                                      // [RQ18]
    end else if (active) begin
      unique case (i_cfg.drive)                                // [RQ16] [RQ18]
        DRV_HIZ:         next_pad.oe = 1'b0;
        DRV_PUSH_PULL:   next_pad.oe = 1'b1;
        DRV_LOW_WEAKHI:  begin
          next_pad.oe      = ~data;
          next_pad.pull_up = data;
        end
        DRV_LOW_ONLY:    next_pad.oe = ~data;
        DRV_WEAKLO_HIGH: begin
          next_pad.oe      = data;
          next_pad.pull_dn = ~data;
        end
        DRV_HIGH_ONLY:   next_pad.oe = data;
        default:         next_pad.oe = 1'b0;                   // [RQ17]
      endcase
    end
  end

  // Pad controls come from flip-flops so pins never glitch on decode
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pad <= '0;
    end else begin
      o_pad <= next_pad;
    end
  end

endmodule

// >>> src/cpfm_top.sv
// Pin-function mux: control registers, input monitors, routing, pin drive
// Contract
// [RQ1] - Input pin enable bit 1: 0 off, 1 input.
// [RQ2] - SPI mode: input pin is chip select, enable ignored.
// [RQ3] - Value bit 7: bidir A output level as GPO.
// [RQ4] - Value bit 6: bidir B output level as GPO.
// [RQ5] - Value bit 5: output-only pin level as GPO.
// [RQ6] - Value bits 3,2,1 monitor bidir A, bidir B, input pin.
// [RQ7] - Host writes reset values to reserved bits; they read reset.
// [RQ8] - Bits 6-5 pick aux clock: off, bidir A, bidir B, input pin.
// [RQ9] - Bits 4-2 pick second primary data input; 6-7 reserved.
// [RQ10] - Config 0 bit 1: bit clock from pin or secondary port.
// [RQ11] - Config 0 bit 0: frame sync from pin or secondary port.
// [RQ12] - Function bits 7-4 reset 0101b; codes 0-4 basic functions.
// [RQ13] - Function codes 5-13 pick serial and clock outputs.
// [RQ14] - Code 14 loops data input back; 15 reserved.
// [RQ15] - Config 1 bit 3: serial out level as GPO.
// [RQ16] - Drive bits 2-0, reset 010b, pick six drive styles.
// [RQ17] - Host never writes drive codes 6 or 7.
// [RQ18] - Bidir drive uses same codes; ignored for serial outputs.
// [RQ19] - Pin inputs pass two synchroniser flops first.
// [RQ20] - A routed pin not set as input reads low.
`timescale 1ns/10ps
module cpfm_top (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  // Register port
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [7:0]           o_reg_rdata,
  output logic                      o_reg_rvalid,
  // Control interface mode
  input  wire logic                 i_spi_mode,
  // Pin settings kept outside this block
  input  wire cpfm_pkg::cpfm_func_e  i_bidir_a_function,
  input  wire cpfm_pkg::cpfm_drive_e i_bidir_a_drive,
  input  wire cpfm_pkg::cpfm_func_e  i_bidir_b_function,
  input  wire cpfm_pkg::cpfm_drive_e i_bidir_b_drive,
  input  wire cpfm_pkg::cpfm_func_e  i_outonly_function,
  input  wire cpfm_pkg::cpfm_drive_e i_outonly_drive,
  // Internal function sources
  input  wire cpfm_pkg::cpfm_src_s   i_src,
  // Pin and clock inputs, asynchronous to i_sys_clk
  input  wire logic                 i_bidir_pin_a,
  input  wire logic                 i_bidir_pin_b,
  input  wire logic                 i_input_only_pin,
  input  wire logic                 i_serial_out_pin,
  input  wire logic                 i_primary_din,
  input  wire logic                 i_bitclk_pin,
  input  wire logic                 i_framesync_pin,
  input  wire logic                 i_sec_bitclk,
  input  wire logic                 i_sec_framesync,
  // Pad controls
  output cpfm_pkg::cpfm_pad_s       o_bidir_pin_a,
  output cpfm_pkg::cpfm_pad_s       o_bidir_pin_b,
  output cpfm_pkg::cpfm_pad_s       o_output_only_pin,
  output cpfm_pkg::cpfm_pad_s       o_serial_out_pin,
  // Routed signals toward the core
  output logic                      o_aux_clock,
  output logic                      o_primary_second_input,
  output logic                      o_primary_bitclk,
  output logic                      o_primary_framesync,
  output logic                      o_spi_chip_select_n,
  output logic                      o_input_only_data
);
  import cpfm_pkg::*;

  ////////////////////////////////////////
  // Declarations
  logic [7:0]          input_pin_config;
  logic [7:0]          pin_values;
  logic [7:0]          routing_cfg0;
  logic [7:0]          serial_out_cfg;
  logic [SYNC_W-1:0]   sync_meta;
  logic [SYNC_W-1:0]   sync_in;
  logic [SYNC_W-1:0]   pin_raw;
  logic                a_is_input;
  logic                b_is_input;
  logic                inonly_is_input;
  logic                sout_is_input;
  logic [4:0]          gated_src;
  logic [7:0]          next_rdata;
  cpfm_func_e          sout_func;
  cpfm_drive_e         sout_drive;
  cpfm_pin_cfg_s       pin_cfg   [NUM_PINS];
  cpfm_pad_s           pin_pad   [NUM_PINS];
  logic [NUM_PINS-1:0] pin_loop;
  logic [NUM_PINS-1:0] pin_drv_sr;

  ////////////////////////////////////////
  // Functions

  // Masked register update; reserved bits keep their reset value
  function automatic logic [7:0] masked_write(
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic [7:0] wmask
  );
    masked_write = (cur & ~wmask) | (wdata & wmask);
  endfunction

  // Source pick shared by aux clock and second data input routing
  function automatic logic pick_src(
    input logic [2:0] sel,
    input logic [4:0] src
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      3'h1:    r = src[0];
      3'h2:    r = src[1];
      3'h3:    r = src[2];
      3'h4:    r = src[3];
      3'h5:    r = src[4];
      default: r = 1'b0;
    endcase
    pick_src = r;
  endfunction

  ////////////////////////////////////////
  // Input synchronisers; order follows the SI_ indices, bit 0 last
  assign pin_raw = {i_sec_framesync, i_sec_bitclk, i_framesync_pin, i_bitclk_pin,
                    i_primary_din, i_serial_out_pin, i_input_only_pin,
                    i_bidir_pin_b, i_bidir_pin_a};

  // One process owns both stages; the first stage feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sync_meta <= '0;
      sync_in   <= '0;
    end else begin
      sync_meta <= pin_raw;                                // [RQ19]
      sync_in   <= sync_meta;                              // [RQ19]
    end
  end

  ////////////////////////////////////////
  // Register writes; only masked bits change, including undocumented input pin config bit 0
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      input_pin_config <= RST_INPUT_PIN_CONFIG;
    end else if (i_reg_wr && i_reg_addr == ADDR_INPUT_PIN_CONFIG) begin
      input_pin_config <= masked_write(input_pin_config, i_reg_wdata,
                                       WMASK_INPUT_PIN_CONFIG); // [RQ1] [RQ7]
    end
  end

  // Monitor bits are not stored here; they are merged at read time
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_values <= RST_PIN_VALUES;
    end else if (i_reg_wr && i_reg_addr == ADDR_PIN_VALUES) begin
      pin_values <= masked_write(pin_values, i_reg_wdata,
                                 WMASK_PIN_VALUES);       // [RQ3] [RQ4] [RQ5]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      routing_cfg0 <= RST_ROUTING_CFG0;
    end else if (i_reg_wr && i_reg_addr == ADDR_ROUTING_CFG0) begin
      routing_cfg0 <= masked_write(routing_cfg0, i_reg_wdata,
                                   WMASK_ROUTING_CFG0);   // [RQ7]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      serial_out_cfg <= RST_SERIAL_OUT_CFG;               // [RQ12] [RQ16]
    end else if (i_reg_wr && i_reg_addr == ADDR_SERIAL_OUT_CFG) begin
      serial_out_cfg <= masked_write(serial_out_cfg, i_reg_wdata,
                                     WMASK_SERIAL_OUT_CFG);
    end
  end

  ////////////////////////////////////////
  // Which pins currently act as inputs
  assign a_is_input      = (i_bidir_a_function == FN_INPUT);
  assign b_is_input      = (i_bidir_b_function == FN_INPUT);
  // SPI mode takes the pin over as chip select whatever the enable says
  assign inonly_is_input = input_pin_config[POS_INPUT_PIN_ENABLE]
                           && !i_spi_mode;                // [RQ1] [RQ2]
  assign sout_func       = cpfm_func_e'(serial_out_cfg[POS_SOUT_FUNC +: 4]);
  assign sout_drive      = cpfm_drive_e'(serial_out_cfg[POS_SOUT_DRIVE +: 3]);
  assign sout_is_input   = (sout_func == FN_INPUT);       // [RQ12]

  // Routed levels; a pin not set as input reads low
  assign gated_src[0] = sync_in[SI_BIDIR_A] & a_is_input;      // [RQ20]
  assign gated_src[1] = sync_in[SI_BIDIR_B] & b_is_input;      // [RQ20]
  assign gated_src[2] = sync_in[SI_INONLY]  & inonly_is_input; // [RQ20]
  assign gated_src[3] = sync_in[SI_SOUT]    & sout_is_input;   // [RQ20]
  assign gated_src[4] = sync_in[SI_PRI_DIN];

  ////////////////////////////////////////
  // Register reads: one-cycle registered answer, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_reg_addr)
      ADDR_INPUT_PIN_CONFIG: next_rdata = input_pin_config;      // [RQ7]
      ADDR_PIN_VALUES: begin
        next_rdata = pin_values;
        next_rdata[POS_BIDIR_A_IN] = gated_src[0];               // [RQ6]
        next_rdata[POS_BIDIR_B_IN] = gated_src[1];               // [RQ6]
        next_rdata[POS_INONLY_IN]  = gated_src[2];               // [RQ6]
      end
      ADDR_ROUTING_CFG0:     next_rdata = routing_cfg0;
      ADDR_SERIAL_OUT_CFG:   next_rdata = serial_out_cfg;
      default:               next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////
  // Routing toward the core; registered to keep outputs clean
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_aux_clock            <= 1'b0;
      o_primary_second_input <= 1'b0;
    end else begin
      o_aux_clock <= pick_src({1'b0, routing_cfg0[POS_AUX_CLK_SEL +: 2]},
                              gated_src);                    // [RQ8]
      // Codes 6 and 7 fall to the disabled default
      o_primary_second_input <= pick_src(routing_cfg0[POS_DIN2_SEL +: 3],
                                         gated_src);         // [RQ9]
    end
  end

  // Primary serial clocks; an extra register stage adds fixed latency
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_primary_bitclk    <= 1'b0;
      o_primary_framesync <= 1'b0;
    end else begin
      o_primary_bitclk <= routing_cfg0[POS_BITCLK_SRC]
                          ? sync_in[SI_SEC_BCLK]
                          : sync_in[SI_BITCLK];              // [RQ10]
      o_primary_framesync <= routing_cfg0[POS_FSYNC_SRC]
                             ? sync_in[SI_SEC_FSYNC]
                             : sync_in[SI_FSYNC];            // [RQ11]
    end
  end

  // Chip select is idle high outside SPI mode
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_spi_chip_select_n <= 1'b1;
      o_input_only_data   <= 1'b0;
    end else begin
      o_spi_chip_select_n <= i_spi_mode ? sync_in[SI_INONLY] : 1'b1; // [RQ2]
      o_input_only_data   <= gated_src[2];                  // [RQ1]
    end
  end

  ////////////////////////////////////////
  // Pin drivers; only the serial out pin supports loopback
  assign pin_cfg[PIN_A] = '{func:  i_bidir_a_function,
                            level: pin_values[POS_BIDIR_A_OUT],   // [RQ3]
                            drive: i_bidir_a_drive};
  assign pin_cfg[PIN_B] = '{func:  i_bidir_b_function,
                            level: pin_values[POS_BIDIR_B_OUT],   // [RQ4]
                            drive: i_bidir_b_drive};
  assign pin_cfg[PIN_OUTONLY] = '{func:  i_outonly_function,
                                  level: pin_values[POS_OUTONLY_OUT], // [RQ5]
                                  drive: i_outonly_drive};
  assign pin_cfg[PIN_SOUT] = '{func:  sout_func,
                               level: serial_out_cfg[POS_SOUT_LEVEL], // [RQ15]
                               drive: sout_drive};                    // [RQ16]

  assign pin_loop   = 4'h8;                                 // [RQ14]
  // Serial out keeps its drive style for every driving function, serial ones included
  assign pin_drv_sr = 4'h8;                                 // [RQ18]

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      cpfm_pin_drv u_drv (
        .i_sys_clk        (i_sys_clk),
        .i_srst           (i_srst),
        .i_cfg            (pin_cfg[gp]),
        .i_src            (i_src),
        .i_loop_data      (sync_in[SI_PRI_DIN]),
        .i_has_loop       (pin_loop[gp]),
        .i_drive_on_serial(pin_drv_sr[gp]),
        .o_pad            (pin_pad[gp])
      );
    end
  endgenerate

  assign o_bidir_pin_a     = pin_pad[PIN_A];
  assign o_bidir_pin_b     = pin_pad[PIN_B];
  assign o_output_only_pin = pin_pad[PIN_OUTONLY];
  assign o_serial_out_pin  = pin_pad[PIN_SOUT];

endmodule

// >>> sim/cpfm_top_sva.sv
// Checker for register port, chip select, clock routing and serial-out pad
`timescale 1ns/10ps
module cpfm_chk
  import cpfm_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_rvalid,
  input wire logic       i_spi_mode,
  input wire logic       o_spi_chip_select_n,
  input wire logic       i_bitclk_pin,
  input wire logic       i_sec_bitclk,
  input wire logic       o_primary_bitclk,
  input wire logic       i_framesync_pin,
  input wire logic       i_sec_framesync,
  input wire logic       o_primary_framesync,
  input wire cpfm_pad_s  o_serial_out_pin
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  logic [7:0] cfg0, sout;
  logic [2:0] up;
  // Register shadows; up waits out the pin synchroniser after each reset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cfg0 <= 8'h00;
      sout <= 8'h52;
      up   <= 3'h0;
    end else begin
      if (up != 3'h4) up <= up + 3'h1;
      if (i_reg_wr && i_reg_addr == 8'h0F) cfg0 <= i_reg_wdata & 8'h7F;
      if (i_reg_wr && i_reg_addr == 8'h10) sout <= i_reg_wdata;
    end
  end
  property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_unmap;
    i_reg_rd && (i_reg_addr < 8'h0D || i_reg_addr > 8'h10) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_sout_rd; i_reg_rd && i_reg_addr == 8'h10 |=> o_reg_rdata == $past(sout); endproperty
  a_sout_rd: assert property (p_sout_rd) else $error("serial-out config readback");
  property p_cs; !i_spi_mode [*3] |-> o_spi_chip_select_n; endproperty
  a_cs: assert property (p_cs) else $error("chip select outside SPI mode");
  // Routed clocks: one cycle from config, three from the pin
  property p_bclk;
    up == 3'h4 |-> o_primary_bitclk == ($past(cfg0[1]) ? $past(i_sec_bitclk, 3)
                                                       : $past(i_bitclk_pin, 3));
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock routing");
  property p_fs;
    up == 3'h4 |-> o_primary_framesync == ($past(cfg0[0]) ? $past(i_sec_framesync, 3)
                                                          : $past(i_framesync_pin, 3));
  endproperty
  a_fs: assert property (p_fs) else $error("frame sync routing");
  property p_gpo;
    $past(sout[7:4]) == 4'h2 && $past(sout[2:0]) == 3'h1
      |-> o_serial_out_pin.oe && o_serial_out_pin.out == $past(sout[3]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("serial-out level");
  property p_hiz; $past(sout[2:0]) == 3'h0 |-> o_serial_out_pin[2:0] == 3'h0; endproperty
  a_hiz: assert property (p_hiz) else $error("serial-out not floating");
  c_loop: cover property ($past(sout[7:4]) == 4'hE && o_serial_out_pin.oe);
  c_spi: cover property (i_spi_mode && !o_spi_chip_select_n);
  c_unmap: cover property (i_reg_rd && i_reg_addr == 8'h11);
endmodule
bind cpfm_top cpfm_chk chk (.*);

// >>> sim/cpfm_serial_peer.sv
// Serial peripheral model: bit clocks and frame syncs, still while i_run is low
`timescale 1ns/10ps
module cpfm_serial_peer (
  input  wire logic i_run,
  output logic      o_bclk,
  output logic      o_fsync,
  output logic      o_sec_bclk,
  output logic      o_sec_fsync
);
  int n;
  // Odd 10 ps offset keeps every edge away from the system clock edges
  initial begin
    {o_bclk, o_fsync, o_sec_bclk, o_sec_fsync} = 4'h0;
    n = 0;
    #0.01;
    forever begin
      #17.34;
      if (i_run) begin
        n++;
        o_bclk = ~o_bclk;
        o_sec_bclk = o_bclk ^ n[2];
        o_fsync = (n % 16) < 2;
        o_sec_fsync = (n % 16) == 8;
      end
    end
  end
endmodule

// >>> sim/tb_cpfm_top.sv
// Testbench: registers, monitors, routing and pad drive of the pin mux
`timescale 1ns/10ps
module tb_cpfm_top;
  import cpfm_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, spi = 0, run = 0;
  logic pa = 0, pb = 0, pc = 0, ps = 0, pd = 0, v;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lv, q[$];
  logic rvalid, aux, din2, bclk, fsync, csn, ido, pbk, pfs, sbk, sfs;
  cpfm_func_e fa = FN_DISABLED, fb = FN_DISABLED, fo = FN_GPO;
  cpfm_src_s src = '0;
  cpfm_drive_e da = DRV_PUSH_PULL;
  cpfm_pad_s pad_a, pad_b, pad_o, pad_s;
  logic [7:0] ad[6] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h52, 8'h00};
  logic [7:0] wm[6] = '{8'h00, 8'h02, 8'hE0, 8'h7F, 8'hED, 8'h00};
  logic [3:0] dt[12] = '{4'h0, 4'h0, 4'h4, 4'hC, 4'h4, 4'h2, 4'h4, 4'h0, 4'h1, 4'hC, 4'h0, 4'hC};
  int mismatches = 0, compares = 0;
  cpfm_top dut (.i_sys_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_spi_mode(spi), .i_bidir_a_function(fa), .i_bidir_a_drive(da),
    .i_bidir_b_function(fb), .i_bidir_b_drive(DRV_PUSH_PULL), .i_outonly_function(fo),
    .i_outonly_drive(DRV_PUSH_PULL), .i_src(src), .i_bidir_pin_a(pa), .i_bidir_pin_b(pb),
    .i_input_only_pin(pc), .i_serial_out_pin(ps), .i_primary_din(pd), .i_bitclk_pin(pbk),
    .i_framesync_pin(pfs), .i_sec_bitclk(sbk), .i_sec_framesync(sfs),
    .o_bidir_pin_a(pad_a), .o_bidir_pin_b(pad_b), .o_output_only_pin(pad_o),
    .o_serial_out_pin(pad_s), .o_aux_clock(aux), .o_primary_second_input(din2),
    .o_primary_bitclk(bclk), .o_primary_framesync(fsync), .o_spi_chip_select_n(csn),
    .o_input_only_data(ido));
  cpfm_serial_peer peer (.i_run(run), .o_bclk(pbk), .o_fsync(pfs), .o_sec_bclk(sbk),
    .o_sec_fsync(sfs));
  always #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes drop for one idle cycle so no signal is set twice in a step
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    tick();
    wr = 0;
    tick();
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    addr = a;
    rd = 1;
    tick();
    rd = 0;
    tick();
  endtask
  function automatic logic [7:0] padv(input cpfm_pad_s p);
    return {4'h0, p.out & p.oe, p.oe, p.pull_up, p.pull_dn};
  endfunction
  // Each read answer meets the oldest noted expectation
  always @(posedge clk) begin
    if (rvalid === 1'b1) cmp(rdata, q.size() > 0 ? q.pop_front() : 8'hEE);
  end
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(73810));
    tick(6);
    srst = 0;
    // Reset values; legal writes keep reserved bits at reset value
    foreach (ad[i]) rreg(ad[i], rv[i]);
    foreach (ad[i]) wreg(ad[i], wm[i]);
    foreach (ad[i]) rreg(ad[i], wm[i]);
    foreach (ad[i]) wreg(ad[i], rv[i]);
    // Monitors, input enable and chip select on random pin levels
    fa = FN_INPUT;
    fb = FN_INPUT;
    for (int i = 0; i < 8; i++) begin
      wreg(8'h0D, {6'h00, i[0], 1'b0});
      {pa, pb, pc} = 3'($urandom_range(7));
      spi = i[2];
      tick(3);
      rreg(8'h0E, {4'h0, pa, pb, pc & i[0] & ~spi, 1'b0});
      cmp(8'(csn), 8'(spi ? pc : 1'b1));
      cmp(8'(ido), 8'(pc & i[0] & ~spi));
    end
    // Every select code; pin B is not an input, so it routes as low
    spi = 0;
    fb = FN_DISABLED;
    wreg(8'h10, 8'h12);
    for (int s = 0; s < 32; s++) begin
      {pa, pb, pc, ps, pd} = 5'($urandom);
      lv = {2'b00, pd, ps, pc, 1'b0, pa, 1'b0};
      wreg(8'h0F, {1'b0, s[4:3], s[2:0], 2'b00});
      tick(2);
      cmp(8'(aux), 8'(lv[s[4:3]]));
      cmp(8'(din2), 8'(lv[s[2:0]]));
    end
    // Peer clocks under each source pairing
    run = 1;
    for (int s = 0; s < 4; s++) begin
      wreg(8'h0F, 8'(s));
      tick(40);
    end
    run = 0;
    // Value bits drive the GPO pins
    fa = FN_GPO;
    fb = FN_GPO;
    for (int i = 0; i < 8; i++) begin
      wreg(8'h0E, {i[2:0], 5'h00});
      cmp({pad_a.out, pad_b.out, pad_o.out, pad_a.oe, pad_b.oe, pad_o.oe, 2'b00},
          {i[2:0], 5'h1C});
    end
    // A serial function on bidir A drives hard even with a floating style
    fa = FN_PRI_DOUT;
    da = DRV_HIZ;
    src = '1;
    tick(2);
    cmp(8'(pad_a[3:2]), 8'h03);
    // Every serial-out function, push-pull, both source levels
    for (int f = 0; f < 32; f++) begin
      v = f[4];
      pd = v;
      src = cpfm_src_s'({11{v}});
      wreg(8'h10, {f[3:0], 4'h1});
      tick(2);
      cmp(padv(pad_s), (f[3:0] < 2 || f[3:0] == 15) ? 8'h00
                        : {4'h0, f[3:0] != 2 && v, 3'b100});
    end
    // Usable drive styles at both levels; codes 6 and 7 unused
    for (int k = 0; k < 12; k++) begin
      wreg(8'h10, {4'h2, k[0], k[3:1]});
      cmp(padv(pad_s), 8'(dt[k]));
    end
    tick(4);
    final_report();
  end
endmodule
